// *** wdtk_counter.v ***
// Timeout counter of the keyed watchdog with restart and terminal compare.
`include "wdtk_regs.vh"

module wdtk_counter (
  input wire clk,
  input wire rst_n,
  input wire en,
  input wire clr,
  input wire [`WDTK_CNT_W-1:0] term,
  output reg expired_r
);

  reg [`WDTK_CNT_W-1:0] cnt_r;
  wire [`WDTK_CNT_W-1:0] last = (term == {`WDTK_CNT_W{1'b0}}) ?
                                {`WDTK_CNT_W{1'b0}} : term - {{(`WDTK_CNT_W-1){1'b0}}, 1'b1};

  // ----------------------------------------------------------------------------
  // Count one step per enabled clock, wrap and pulse at the selected terminal value
  // ----------------------------------------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= {`WDTK_CNT_W{1'b0}};
      expired_r <= 1'b0;
    end else if (clr) begin
      cnt_r <= {`WDTK_CNT_W{1'b0}};
      expired_r <= 1'b0;
    end else if (en) begin
      if (cnt_r >= last) begin
        cnt_r <= {`WDTK_CNT_W{1'b0}};
        expired_r <= 1'b1;
      end else begin
        cnt_r <= cnt_r + {{(`WDTK_CNT_W-1){1'b0}}, 1'b1};
        expired_r <= 1'b0;
      end
    end else begin
      expired_r <= 1'b0;
    end
  end

endmodule

// *** wdtk_regs.vh ***
// Register map, field positions, keys and timing constants of the keyed watchdog.
`ifndef WDTK_REGS_VH
`define WDTK_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define WDTK_ADDR_W 2
`define WDTK_OFS_CTRL 2'h0
`define WDTK_OFS_STAT 2'h1
`define WDTK_OFS_MASK 2'h2

// ----------------------------------------------------------------------------
// Watchdog control fields
// ----------------------------------------------------------------------------
`define WDTK_DATA_W 16
`define WDTK_BIT_ENA 15
`define WDTK_BIT_MODE_RST 14
`define WDTK_BIT_RST_FLAG 13
`define WDTK_BIT_NMI_FLAG 12
`define WDTK_BIT_LOCKED 11
`define WDTK_SEL_HI 2
`define WDTK_SEL_LO 0
`define WDTK_SEL_W 3
`define WDTK_SEL_MAX 3'h7
`define WDTK_CTRL_RESET 16'hC007

// ----------------------------------------------------------------------------
// Key words
// ----------------------------------------------------------------------------
`define WDTK_KEY_UNLOCK1 16'h3333
`define WDTK_KEY_UNLOCK2 16'hCCCC
`define WDTK_KEY_RESTART1 16'hAAAA
`define WDTK_KEY_RESTART2 16'h5555

// ----------------------------------------------------------------------------
// Interrupt status and mask layout
// ----------------------------------------------------------------------------
`define WDTK_IRQ_W 3
`define WDTK_IRQ_NMI 0
`define WDTK_IRQ_WRST 1
`define WDTK_IRQ_ABORT 2
`define WDTK_IRQ_NONE 3'h0

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define WDTK_TIMEOUT_MS 1670
`define WDTK_REF_CLK_KHZ 40000
`define WDTK_CNT_W 26
// 1670 ms of a 40 MHz clock, already sized to the counter width.
`define WDTK_MAX_TIMEOUT_CYC 26'h3FB4980
`define WDTK_STRAP_W 8
`define WDTK_FILL_W 2
`define WDTK_FILL_DONE 2'h3

`endif

// *** wdtk_tb.sv ***
// Self-checking bench for the keyed watchdog with a register model.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam integer T = 256;
  reg MCLK = 1'b0;
  reg RST_N = 1'b0;
  reg [1:0] ADDR = 2'h0;
  reg [15:0] WDATA = 16'h0000;
  reg WR = 1'b0;
  reg RD = 1'b0;
  reg [7:0] STRAP_CFG = 8'h00;
  wire [15:0] RDATA;
  wire NMI_REQ;
  wire WDT_RST_REQ;
  wire IRQ;
  wire [7:0] CFG_HELD;
  integer fails = 0;
  integer samples_checked = 0;
  integer seed = 32'h824A;
  integer cyc = 0;
  integer m_ctrl = 16'hC007;
  integer m_stat = 0;
  integer m_mask = 0;
  integer ks = 0;
  integer i;
  reg [7:0] strap0;
  wdtk_top #(.MAX_TIMEOUT_CYC(26'h100)) uut (.MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .NMI_REQ(NMI_REQ),
    .WDT_RST_REQ(WDT_RST_REQ), .IRQ(IRQ), .STRAP_CFG(STRAP_CFG), .CFG_HELD(CFG_HELD));
  initial forever #2 MCLK = ~MCLK;
  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task finish_test;
    begin
      $display("checked %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task chk(input string nm, input [15:0] e, input [15:0] g);
    begin
      samples_checked = samples_checked + 1;
      if (g !== e) begin
        fails = fails + 1;
        $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task wr(input [1:0] a, input [15:0] d);
    begin
      @(posedge MCLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
      if (a == 2'h1) m_stat = m_stat & ~d;
      if (a == 2'h2) m_mask = d & 7;
      if (a == 2'h0) begin
        m_ctrl = m_ctrl & 16'hDFFF;
        if (ks == 2) begin
          if (m_ctrl & 16'h0800) m_ctrl = m_ctrl & (d | 16'hEFFF);
          else m_ctrl = (m_ctrl & 16'h1000 & d) | (d & 16'hC007) | 16'h0800;
          ks = 0;
        end else if (ks == 1 && d == 16'hCCCC) ks = 2;
        else if (ks == 3 && d == 16'h5555) ks = 0;
        else begin
          // A wrong word aborts, then may itself open a new sequence.
          if (ks != 0) m_stat = m_stat | 4;
          ks = (d == 16'h3333) ? 1 : (d == 16'hAAAA) ? 3 : 0;
        end
      end
    end
  endtask
  task rd(input [1:0] a, input string nm);
    begin
      @(posedge MCLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1;
      chk(nm, (a == 2'h0) ? m_ctrl : (a == 2'h1) ? m_stat : (a == 2'h2) ? m_mask : 0, RDATA);
      if (a == 2'h0) begin
        m_ctrl = m_ctrl & 16'hDFFF;
        if (ks != 0) m_stat = m_stat | 4;
        ks = 0;
      end
    end
  endtask
  task irq_chk;
    begin
      repeat (3) @(posedge MCLK);
      #1;
      chk("irq", {15'h0000, (m_stat & m_mask) != 0}, {15'h0000, IRQ});
    end
  endtask
  task wait_req(input integer is_rst, input integer lo, input integer hi);
    integer k;
    begin
      k = 0;
      while (k <= hi && (is_rst ? WDT_RST_REQ : NMI_REQ) !== 1'b1) begin
        @(posedge MCLK);
        #1;
        k = k + 1;
      end
      chk("request delay", 16'h0001, {15'h0000, k >= lo && k <= hi});
      @(posedge MCLK);
      #1;
    end
  endtask
  // The model follows each timeout action one edge after its pulse.
  always @(posedge MCLK) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      fails = fails + 1;
      finish_test;
    end
    if (NMI_REQ === 1'b1) begin
      m_ctrl = m_ctrl | 16'h1000;
      m_stat = m_stat | 1;
    end
    if (WDT_RST_REQ === 1'b1) begin
      m_ctrl = 16'hE007;
      ks = 0;
      m_stat = m_stat | 2;
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    strap0 = $random(seed) | 8'h01;
    STRAP_CFG = strap0;
    repeat (10) @(posedge MCLK);
    RST_N <= 1'b1;
    rd(2'h0, "ctrl after reset");
    rd(2'h3, "unmapped read");
    wr(2'h3, $random(seed));
    wr(2'h2, 16'h0007);
    rd(2'h0, "ctrl after unmapped write");
    // Straps change before the watchdog reset, so a resample would show.
    STRAP_CFG <= ~strap0;
    wait_req(1, T - 20, T + 4);
    irq_chk;
    rd(2'h0, "ctrl after watchdog reset");
    rd(2'h0, "ctrl after flag read");
    rd(2'h1, "status after watchdog reset");
    chk("held straps", {8'h00, strap0}, {8'h00, CFG_HELD});
    wr(2'h1, 16'h0007);
    irq_chk;
    for (i = 0; i < 6; i = i + 1) begin
      repeat (T - 60) @(posedge MCLK);
      wr(2'h0, 16'hAAAA);
      repeat ({$random(seed)} % 3) rd(2'h1, "status between keys");
      wr(2'h0, 16'h5555);
    end
    chk("no timeout during restarts", 16'h0000, m_stat);
    rd(2'h1, "status after restarts");
    wr(2'h2, 16'h0004);
    wr(2'h0, 16'h3333);
    wr(2'h0, $random(seed) & 16'h0F0F);
    irq_chk;
    wr(2'h1, 16'h0004);
    wr(2'h0, 16'hAAAA);
    rd(2'h0, "ctrl read aborts");
    rd(2'h1, "abort status");
    wr(2'h2, 16'h0000);
    irq_chk;
    wr(2'h0, 16'h3333);
    rd(2'h2, "mask between keys");
    wr(2'h0, 16'hCCCC);
    wr(2'h0, 16'h8003);
    rd(2'h0, "ctrl configured");
    wr(2'h0, 16'h3333);
    wr(2'h0, 16'hCCCC);
    wr(2'h0, 16'hC007);
    rd(2'h0, "second config ignored");
    wait_req(0, 1, 12);
    rd(2'h0, "nmi flag");
    wait_req(1, 6, 20);
    rd(2'h0, "ctrl after second timeout");
    wr(2'h0, 16'h3333);
    wr(2'h0, 16'hCCCC);
    wr(2'h0, 16'h8003);
    wait_req(0, 1, 24);
    wr(2'h0, 16'h3333);
    wr(2'h0, 16'hCCCC);
    wr(2'h0, 16'h0000);
    rd(2'h0, "nmi flag cleared");
    wait_req(0, 1, 24);
    rd(2'h1, "final status");
    finish_test;
  end
endmodule

// *** wdtk_top.v ***
// Keyed-access watchdog: control register, key sequences, timeout actions and interrupts.
//
// Behaviour
// - After reset running, longest timeout, reset mode.
// - Configuration accepted only once per reset.
// - Config needs 3333h then CCCCh first.
// - Traffic to other registers between keys is harmless; a control read aborts.
// - AAAAh then 5555h restarts the count.
// - Running count is never readable.
// - Longest timeout about 1.67 s at 40 MHz.
// - Timeout gives NMI or system reset.
// - NMI timeout sets flag bit 12.
// - Timeout with flag set causes reset.
// - Watchdog reset sets flag bit 13.
// - Any control access clears reset flag.
// - Watchdog reset keeps pin-sampled configuration.
// - Otherwise watchdog reset equals system reset; status and mask are kept.
`include "wdtk_regs.vh"

module wdtk_top #(
  parameter [`WDTK_CNT_W-1:0] MAX_TIMEOUT_CYC = `WDTK_MAX_TIMEOUT_CYC
) (
  input wire MCLK,
  input wire RST_N,
  input wire [`WDTK_ADDR_W-1:0] ADDR,
  input wire [`WDTK_DATA_W-1:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [`WDTK_DATA_W-1:0] RDATA,
  output reg NMI_REQ,
  output reg WDT_RST_REQ,
  output reg IRQ,
  input wire [`WDTK_STRAP_W-1:0] STRAP_CFG,
  output reg [`WDTK_STRAP_W-1:0] CFG_HELD
);

  // ----------------------------------------------------------------------------
  // Key sequence states
  // ----------------------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_KEY1 = 2'h1;
  localparam [1:0] ST_UNLK = 2'h2;
  localparam [1:0] ST_RKEY = 2'h3;

  // Named copy of the control reset word so single fields can be picked out of it.
  localparam [`WDTK_DATA_W-1:0] CTRL_RST = `WDTK_CTRL_RESET;

  // A word that breaks a sequence may itself open a new one, so it is checked again.
  function [1:0] first_key;
    input [`WDTK_DATA_W-1:0] d;
    begin
      if (d == `WDTK_KEY_UNLOCK1) begin
        first_key = ST_KEY1;
      end else if (d == `WDTK_KEY_RESTART1) begin
        first_key = ST_RKEY;
      end else begin
        first_key = ST_IDLE;
      end
    end
  endfunction

  // Terminal value shrinks by half for every step below the longest selection.
  function [`WDTK_CNT_W-1:0] term_of;
    input [`WDTK_SEL_W-1:0] sel;
    begin
      term_of = MAX_TIMEOUT_CYC >> (`WDTK_SEL_MAX - sel);
    end
  endfunction

  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg ena_r;
  reg mode_rst_r;
  reg [`WDTK_SEL_W-1:0] sel_r;
  reg locked_r;
  reg nmi_flag_r;
  reg rst_flag_r;
  reg [`WDTK_IRQ_W-1:0] stat_r;
  reg [`WDTK_IRQ_W-1:0] mask_r;
  reg restart;
  reg cfg_apply;
  reg abort;
  wire expired;

  wire ctrl_wr = WR && (ADDR == `WDTK_OFS_CTRL);
  wire ctrl_rd = RD && (ADDR == `WDTK_OFS_CTRL);
  wire stat_wr = WR && (ADDR == `WDTK_OFS_STAT);
  wire mask_wr = WR && (ADDR == `WDTK_OFS_MASK);

  // Timeout with reset mode, or with the NMI flag still pending, resets the watchdog.
  wire fire_rst = expired && (mode_rst_r || nmi_flag_r);
  wire fire_nmi = expired && !mode_rst_r && !nmi_flag_r;

  // ----------------------------------------------------------------------------
  // Key sequence decode
  // ----------------------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    restart = 1'b0;
    cfg_apply = 1'b0;
    abort = 1'b0;
    if (ctrl_wr) begin
      case (state_r)
        ST_IDLE: begin
          state_nxt = first_key(WDATA);
        end
        ST_KEY1: begin
          if (WDATA == `WDTK_KEY_UNLOCK2) begin
            state_nxt = ST_UNLK;
          end else begin
            abort = 1'b1;
            state_nxt = first_key(WDATA);
          end
        end
        ST_UNLK: begin
          cfg_apply = 1'b1;
          state_nxt = ST_IDLE;
        end
        ST_RKEY: begin
          if (WDATA == `WDTK_KEY_RESTART2) begin
            restart = 1'b1;
            state_nxt = ST_IDLE;
          end else begin
            abort = 1'b1;
            state_nxt = first_key(WDATA);
          end
        end
        default: begin
          state_nxt = ST_IDLE;
        end
      endcase
    end else if (ctrl_rd && (state_r != ST_IDLE)) begin
      // Only accesses to the control register itself break a sequence.
      abort = 1'b1;
      state_nxt = ST_IDLE;
    end
  end

  // ----------------------------------------------------------------------------
  // Control state
  // ----------------------------------------------------------------------------
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state_r <= ST_IDLE;
      ena_r <= CTRL_RST[`WDTK_BIT_ENA];
      mode_rst_r <= CTRL_RST[`WDTK_BIT_MODE_RST];
      sel_r <= `WDTK_SEL_MAX;
      locked_r <= 1'b0;
      nmi_flag_r <= 1'b0;
      rst_flag_r <= 1'b0;
    end else if (fire_rst) begin
      // Same values as a system reset; the reset flag and status bit 1 record the cause.
      state_r <= ST_IDLE;
      ena_r <= CTRL_RST[`WDTK_BIT_ENA];
      mode_rst_r <= CTRL_RST[`WDTK_BIT_MODE_RST];
      sel_r <= `WDTK_SEL_MAX;
      locked_r <= 1'b0;
      nmi_flag_r <= 1'b0;
      rst_flag_r <= 1'b1;
    end else begin
      state_r <= state_nxt;
      if (cfg_apply && !locked_r) begin
        ena_r <= WDATA[`WDTK_BIT_ENA];
        mode_rst_r <= WDATA[`WDTK_BIT_MODE_RST];
        sel_r <= WDATA[`WDTK_SEL_HI:`WDTK_SEL_LO];
        locked_r <= 1'b1;
      end
      // A fresh timeout wins over a clearing write in the same cycle.
      if (fire_nmi) begin
        nmi_flag_r <= 1'b1;
      end else if (cfg_apply && !WDATA[`WDTK_BIT_NMI_FLAG]) begin
        nmi_flag_r <= 1'b0;
      end
      if (ctrl_wr || ctrl_rd) begin
        rst_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Timeout counter
  // ----------------------------------------------------------------------------
  wdtk_counter u_cnt (
    .clk(MCLK),
    .rst_n(RST_N),
    .en(ena_r),
    .clr(restart || fire_rst || (cfg_apply && !locked_r)),
    .term(term_of(sel_r)),
    .expired_r(expired)
  );

  // ----------------------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------------------
  wire [`WDTK_IRQ_W-1:0] events = {abort, fire_rst, fire_nmi};

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_r <= `WDTK_IRQ_NONE;
      mask_r <= `WDTK_IRQ_NONE;
    end else begin
      // Set wins over a write-one clear in the same cycle.
      stat_r <= (stat_r & ~(stat_wr ? WDATA[`WDTK_IRQ_W-1:0] : `WDTK_IRQ_NONE)) | events;
      if (mask_wr) begin
        mask_r <= WDATA[`WDTK_IRQ_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Outputs and read data
  // ----------------------------------------------------------------------------
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= {`WDTK_DATA_W{1'b0}};
      NMI_REQ <= 1'b0;
      WDT_RST_REQ <= 1'b0;
      IRQ <= 1'b0;
    end else begin
      NMI_REQ <= fire_nmi;
      WDT_RST_REQ <= fire_rst;
      IRQ <= |(stat_r & mask_r);
      RDATA <= {`WDTK_DATA_W{1'b0}};
      if (RD) begin
        case (ADDR)
          `WDTK_OFS_CTRL: begin
            // The running count has no read path at all.
            RDATA[`WDTK_BIT_ENA] <= ena_r;
            RDATA[`WDTK_BIT_MODE_RST] <= mode_rst_r;
            RDATA[`WDTK_BIT_RST_FLAG] <= rst_flag_r;
            RDATA[`WDTK_BIT_NMI_FLAG] <= nmi_flag_r;
            RDATA[`WDTK_BIT_LOCKED] <= locked_r;
            RDATA[`WDTK_SEL_HI:`WDTK_SEL_LO] <= sel_r;
          end
          `WDTK_OFS_STAT: begin
            RDATA[`WDTK_IRQ_W-1:0] <= stat_r;
          end
          `WDTK_OFS_MASK: begin
            RDATA[`WDTK_IRQ_W-1:0] <= mask_r;
          end
          default: begin
            RDATA <= {`WDTK_DATA_W{1'b0}};
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Pin-sampled configuration
  // ----------------------------------------------------------------------------
  // Captured once after power-on only; a watchdog reset never reaches these flops.
  reg [`WDTK_STRAP_W-1:0] strap_s1_r;
  reg [`WDTK_STRAP_W-1:0] strap_s2_r;
  reg [`WDTK_STRAP_W-1:0] strap_s3_r;
  reg [`WDTK_FILL_W-1:0] fill_r;
  reg captured_r;

  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      strap_s1_r <= {`WDTK_STRAP_W{1'b0}};
      strap_s2_r <= {`WDTK_STRAP_W{1'b0}};
      strap_s3_r <= {`WDTK_STRAP_W{1'b0}};
      fill_r <= {`WDTK_FILL_W{1'b0}};
      captured_r <= 1'b0;
      CFG_HELD <= {`WDTK_STRAP_W{1'b0}};
    end else begin
      strap_s1_r <= STRAP_CFG;
      strap_s2_r <= strap_s1_r;
      strap_s3_r <= strap_s2_r;
      if (fill_r != `WDTK_FILL_DONE) begin
        fill_r <= fill_r + {{(`WDTK_FILL_W-1){1'b0}}, 1'b1};
      end else if (!captured_r && (strap_s2_r == strap_s3_r)) begin
        CFG_HELD <= strap_s3_r;
        captured_r <= 1'b1;
      end
    end
  end

endmodule

// *** wdtk_top_props.sv ***
// Port-level assertions for the keyed watchdog.
module wdtk_props #(
  parameter [25:0] MAX_TIMEOUT_CYC = 26'h100
) (
  input wire MCLK,
  input wire RST_N,
  input wire [1:0] ADDR,
  input wire WR,
  input wire RD,
  input wire [15:0] RDATA,
  input wire NMI_REQ,
  input wire WDT_RST_REQ,
  input wire IRQ,
  input wire [7:0] CFG_HELD
);
  localparam integer T_MAX = MAX_TIMEOUT_CYC;
  integer quiet_r;
  reg dflt_r;
  // ----------------------------------------
  // Cycles since start while the defaults hold
  // ----------------------------------------
  // Any control write may change the timeout, so the timing checks only
  // trust stretches that began with reset values and saw no control write.
  always @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      quiet_r <= 0;
      dflt_r <= 1'b1;
    end else if (WDT_RST_REQ) begin
      quiet_r <= 0;
      dflt_r <= 1'b1;
    end else begin
      quiet_r <= quiet_r + 1;
      if (WR && ADDR == 2'h0) dflt_r <= 1'b0;
    end
  end
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);
  property p_rd_idle;
    !$past(RD) |-> RDATA == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_unmapped;
    RD && ADDR == 2'h3 |=> RDATA == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_nmi_pulse;
    NMI_REQ |=> !NMI_REQ;
  endproperty
  a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi request too long");
  property p_rst_pulse;
    WDT_RST_REQ |=> !WDT_RST_REQ;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("reset request too long");
  property p_one_action;
    !(NMI_REQ && WDT_RST_REQ);
  endproperty
  a_one_action: assert property (p_one_action) else $error("both actions at once");
  property p_first_timeout;
    dflt_r && quiet_r == T_MAX - 2 |-> ##[1:6] WDT_RST_REQ;
  endproperty
  a_first_timeout: assert property (p_first_timeout) else $error("no default reset");
  property p_no_early;
    dflt_r && quiet_r < T_MAX - 3 |-> !WDT_RST_REQ && !NMI_REQ;
  endproperty
  a_no_early: assert property (p_no_early) else $error("timeout too early");
  property p_irq_cause;
    $rose(IRQ) |-> NMI_REQ || WDT_RST_REQ || $past(NMI_REQ || WDT_RST_REQ) || $past(WR || RD, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");
  property p_cfg_kept;
    CFG_HELD != 8'h00 |=> $stable(CFG_HELD);
  endproperty
  a_cfg_kept: assert property (p_cfg_kept) else $error("straps sampled again");
endmodule

bind wdtk_top wdtk_props #(.MAX_TIMEOUT_CYC(MAX_TIMEOUT_CYC)) u_props (.MCLK(MCLK),
  .RST_N(RST_N), .ADDR(ADDR), .WR(WR), .RD(RD), .RDATA(RDATA), .NMI_REQ(NMI_REQ),
  .WDT_RST_REQ(WDT_RST_REQ), .IRQ(IRQ), .CFG_HELD(CFG_HELD));
